// File: switch_monitor_pkg.sv
// Shared constants for the switch input monitor
package switch_monitor_pkg;

    // Number of monitored switch lines
    localparam int          SWITCH_COUNT   = 16;
    // Depth of the inbound serial bit buffer
    localparam int          FIFO_DEPTH     = 16;
    // Width of one buffered word (one serial bit)
    localparam int          FIFO_WIDTH     = 1;
    // Synchroniser stages for every foreign input except the serial data bit
    localparam int          SYNC_STAGES    = 2;
    // Highest serial clock the controller may use, in kHz
    localparam int          SCLK_MAX_KHZ   = 5000;
    // System clock rate in kHz
    localparam int          SYS_CLK_KHZ    = 200000;
    // Least system cycles in one serial clock period
    localparam int          SCLK_MIN_CYCLES = SYS_CLK_KHZ / SCLK_MAX_KHZ;

    // Reset values
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam logic [15:0] MASK_RESET     = 16'h0000;
    localparam logic [15:0] MASK_SW_RESET  = 16'h0000;
    localparam logic        BIT_LOW        = 1'h0;
    localparam logic        BIT_HIGH       = 1'h1;

    // Bit positions in the synchronised pin bundle
    localparam int          POS_SWITCH     = 0;
    localparam int          POS_ENABLE     = 16;
    localparam int          POS_SCLK       = 17;
    localparam int          POS_CS         = 18;
    localparam int          POS_TOGGLE     = 19;
    localparam int          PIN_BUNDLE_W   = 20;

    // Link phase of the shift logic
    typedef enum logic [1:0] {
        LINK_IDLE   = 2'b00,
        LINK_ARMED  = 2'b01,
        LINK_SHIFT  = 2'b10
    } link_state_t;

endpackage

// File: cdc_sync.sv
// Multi-bit level synchroniser, two flip-flops per bit
`timescale 1ns/1ps
module cdc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;

endmodule // cdc_sync

// File: bit_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a clear
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clear,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    wire              doPush = inValid & inReady;
    wire              doPop  = outValid & outReady;

    assign inReady  = (count_r != FULL_COUNT);
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || clear) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doPush) begin
                wrPtr_r <= (wrPtr_r == LAST_SLOT) ? '0 : wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= (rdPtr_r == LAST_SLOT) ? '0 : rdPtr_r + 1'b1;
            end
            if (doPush && !doPop) begin
                count_r <= count_r + 1'b1;
            end else if (doPop && !doPush) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // bit_fifo

// File: spi_switch_input_monitor.sv
// Serial-link sixteen-line switch monitor with maskable open-drain interrupt
`timescale 1ns/1ps
module spi_switch_input_monitor (
    input  wire logic                                        sys_clk,
    input  wire logic                                        reset_n,
    input  wire logic                                        spiClk,
    input  wire logic                                        csN,
    input  wire logic                                        serialIn,
    output logic                                             serialOut,
    output logic                                             serialOutOe,
    output logic                                             irqN,
    output logic                                             irqOe,
    input  wire logic                                        intEn,
    input  wire logic [switch_monitor_pkg::SWITCH_COUNT-1:0] switchLines,
    output logic      [switch_monitor_pkg::SWITCH_COUNT-1:0] maskOut,
    output logic      [switch_monitor_pkg::SWITCH_COUNT-1:0] statusOut
);
    import switch_monitor_pkg::*;

    localparam int MSB = SWITCH_COUNT - 1;

    // ---------------- Link clock domain ----------------
    // Only the sampling of the serial input and its arrival toggle live on the link clock;
    // the link clock stops between frames, so nothing else may wait on it.
    logic linkBit_r;
    logic linkToggle_r;

    always_ff @(negedge spiClk or negedge reset_n) begin
        if (!reset_n) begin
            linkBit_r <= BIT_LOW;
        end else if (!csN) begin
            linkBit_r <= serialIn;
        end
    end

    always_ff @(negedge spiClk or negedge reset_n) begin
        if (!reset_n) begin
            linkToggle_r <= BIT_LOW;
        end else if (!csN) begin
            linkToggle_r <= ~linkToggle_r;
        end
    end

    // ---------------- Pin synchronisation ----------------
    logic [PIN_BUNDLE_W-1:0] pinsRaw;
    logic [PIN_BUNDLE_W-1:0] pinsSync;

    // Select travels inverted so the cleared chain reads as idle
    assign pinsRaw = {linkToggle_r, ~csN, spiClk, intEn, switchLines};

    cdc_sync #(
        .WIDTH   (PIN_BUNDLE_W)
    ) u_pin_sync (
        .clk     (sys_clk),
        .reset_n (reset_n),
        .asyncIn (pinsRaw),
        .syncOut (pinsSync)
    );

    wire                    toggleS = pinsSync[POS_TOGGLE];
    wire                    csNS    = ~pinsSync[POS_CS];
    wire                    sclkS   = pinsSync[POS_SCLK];
    wire                    enableS = pinsSync[POS_ENABLE];
    wire [SWITCH_COUNT-1:0] swS     = pinsSync[POS_SWITCH +: SWITCH_COUNT];

    // ---------------- Edge detection ----------------
    logic toggleSeen_r;
    logic csNPrev_r;
    logic sclkPrev_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            toggleSeen_r <= BIT_LOW;
            csNPrev_r    <= BIT_HIGH;
            sclkPrev_r   <= BIT_LOW;
        end else begin
            toggleSeen_r <= toggleS;
            csNPrev_r    <= csNS;
            sclkPrev_r   <= sclkS;
        end
    end

    wire csLow     = ~csNS;
    wire csFall    = ~csNS & csNPrev_r;
    wire csRise    = csNS & ~csNPrev_r;
    wire sclkRise  = sclkS & ~sclkPrev_r & csLow;
    wire bitArrive = toggleS ^ toggleSeen_r;

    // ---------------- Inbound bit buffer ----------------
    // The captured link bit stays still for a whole serial period, which
    // is far longer than the toggle's trip through the synchroniser.
    logic                  pending_r;
    logic                  fifoInReady;
    logic                  fifoOutValid;
    logic [FIFO_WIDTH-1:0] fifoOutData;
    logic                  fifoPop;
    logic                  pushDone;

    assign pushDone = pending_r & fifoInReady;

    // Arrival wins over the clearing acceptance
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pending_r <= BIT_LOW;
        end else if (bitArrive) begin
            pending_r <= BIT_HIGH;
        end else if (pushDone) begin
            pending_r <= BIT_LOW;
        end
    end

    logic pendingBit_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pendingBit_r <= BIT_LOW;
        end else if (bitArrive) begin
            pendingBit_r <= linkBit_r;
        end
    end

    bit_fifo #(
        .WIDTH    (FIFO_WIDTH),
        .DEPTH    (FIFO_DEPTH)
    ) u_in_fifo (
        .clk      (sys_clk),
        .reset_n  (reset_n),
        .clear    (csFall),
        .inValid  (pending_r),
        .inReady  (fifoInReady),
        .inData   (pendingBit_r),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    // Empty buffer reads as zero, like the idle serial input
    wire nextInBit = fifoOutValid ? fifoOutData[0] : BIT_LOW;

    // ---------------- Input gating ----------------
    logic [SWITCH_COUNT-1:0] heldInputs_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            heldInputs_r <= STATUS_RESET;
        end else if (enableS) begin
            heldInputs_r <= swS;
        end
    end

    wire [SWITCH_COUNT-1:0] gatedInputs = enableS ? swS : heldInputs_r;

    // ---------------- Link phase ----------------
    link_state_t state_r;
    link_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            LINK_IDLE: begin
                if (csFall) begin
                    state_nxt = LINK_ARMED;
                end
            end
            LINK_ARMED: begin
                if (csRise) begin
                    state_nxt = LINK_IDLE;
                end else if (sclkRise) begin
                    state_nxt = LINK_SHIFT;
                end
            end
            LINK_SHIFT: begin
                if (csRise) begin
                    state_nxt = LINK_IDLE;
                end
            end
            default: begin
                state_nxt = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_r <= LINK_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    wire loadShift = sclkRise & (state_r == LINK_ARMED);
    wire stepShift = sclkRise & (state_r == LINK_SHIFT);
    wire commit    = csRise & (state_r != LINK_IDLE);

    // Each shift and the final commit consume one buffered bit
    assign fifoPop = stepShift | commit;

    // ---------------- Shift register ----------------
    logic [SWITCH_COUNT-1:0] shift_r;
    logic [SWITCH_COUNT-1:0] shift_nxt;
    logic [SWITCH_COUNT-1:0] status_r;
    logic [SWITCH_COUNT-1:0] mask_r;

    assign shift_nxt = loadShift ? status_r :
                       stepShift ? {shift_r[MSB-1:0], nextInBit} :
                                   shift_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            shift_r <= STATUS_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    wire [SWITCH_COUNT-1:0] commitValue = {shift_r[MSB-1:0], nextInBit};
    wire                    softReset   = commit &
                                          (commitValue == MASK_SW_RESET);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            status_r <= STATUS_RESET;
        end else if (softReset) begin
            status_r <= STATUS_RESET;
        end else if (csFall) begin
            status_r <= gatedInputs;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mask_r <= MASK_RESET;
        end else if (commit) begin
            mask_r <= commitValue;
        end
    end

    // ---------------- Interrupt ----------------
    // unmasked mismatch
    wire [SWITCH_COUNT-1:0] changed = (gatedInputs ^ status_r) & mask_r;
    wire                    irqWant = enableS & (|changed);

    logic irqOe_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irqOe_r <= BIT_LOW;
        end else begin
            irqOe_r <= irqWant;
        end
    end

    assign irqN  = BIT_LOW;
    assign irqOe = irqOe_r;

    // ---------------- Serial output ----------------
    logic serialOutOe_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            serialOutOe_r <= BIT_LOW;
        end else begin
            serialOutOe_r <= csLow;
        end
    end

    assign serialOut   = shift_r[MSB];
    assign serialOutOe = serialOutOe_r;
    assign maskOut     = mask_r;
    assign statusOut   = status_r;

endmodule // spi_switch_input_monitor

// File: spi_switch_input_monitor_properties.sv
// Port-level checks on the switch monitor
`timescale 1ns/1ps
module spi_switch_input_monitor_properties (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        spiClk,
    input wire logic        csN,
    input wire logic        serialIn,
    input wire logic        serialOut,
    input wire logic        serialOutOe,
    input wire logic        irqN,
    input wire logic        irqOe,
    input wire logic        intEn,
    input wire logic [15:0] switchLines,
    input wire logic [15:0] maskOut,
    input wire logic [15:0] statusOut
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    irq_low_only_a: assert property (irqN == 1'h0)
        else $error("interrupt data not low");
    sdo_idle_off_a: assert property (csN [*5] |-> !serialOutOe)
        else $error("serial out driven while idle");
    sdo_select_on_a: assert property (
        $fell(csN) |-> ##[2:4] serialOutOe)
        else $error("serial out not driven when selected");
    cs_capture_a: assert property ($fell(csN) ##0
        (intEn && $stable(switchLines)) [*5] |-> statusOut == switchLines)
        else $error("status not captured");
    irq_clear_a: assert property (
        $fell(csN) ##0 $stable(switchLines) [*6] |-> !irqOe)
        else $error("interrupt not cleared by select");
    irq_raise_a: assert property ((intEn && csN &&
        |((switchLines ^ statusOut) & maskOut)) [*6] |-> irqOe)
        else $error("interrupt missing");
    irq_masked_a: assert property (
        (((switchLines ^ statusOut) & maskOut) == 16'h0000) [*6]
        |-> !irqOe)
        else $error("masked change raised interrupt");
    irq_off_a: assert property ((!intEn) [*4] |-> !irqOe)
        else $error("interrupt driven while disabled");
    zero_mask_a: assert property (
        $fell(|maskOut) |-> statusOut == 16'h0000)
        else $error("zero mask left status");
    sdo_hold_a: assert property ((!spiClk) [*6] |-> $stable(serialOut))
        else $error("serial out moved without clock");
endmodule // spi_switch_input_monitor_properties

bind spi_switch_input_monitor spi_switch_input_monitor_properties u_props (
    .sys_clk, .reset_n, .spiClk, .csN, .serialIn, .serialOut,
    .serialOutOe, .irqN, .irqOe, .intEn, .switchLines, .maskOut,
    .statusOut);

// File: link_master.sv
// Behavioural serial link controller
`timescale 1ns/1ps
module link_master #(
    parameter int HALF = 100
) (
    output logic      spiClk,
    output logic      csN,
    output logic      serialIn,
    input wire logic  serialOut,
    input wire logic  serialOutOe
);
    initial begin
        spiClk = 1'h0;
        csN = 1'h1;
        serialIn = 1'h0;
    end

    task automatic xfer(input int n, input logic [31:0] tx,
                        output logic [31:0] rx);
        rx = 32'h0;
        // Keep link edges off the system clock edges
        #1;
        csN = 1'h0;
        #(2 * HALF);
        for (int i = n - 1; i >= 0; i--) begin
            spiClk = 1'h1;
            serialIn = tx[i];
            #HALF;
            spiClk = 1'h0;
            #HALF;
            // Floating line reads unknown
            rx[i] = serialOutOe ? serialOut : 1'hx;
        end
        csN = 1'h1;
        // Pull-down takes the released line
        serialIn = 1'h0;
        #(2 * HALF);
    endtask
endmodule // link_master

// File: spi_switch_input_monitor_tb_top.sv
// Self-checking bench for the switch monitor
`timescale 1ns/1ps
module spi_switch_input_monitor_tb_top;
    logic        sys_clk;
    logic        reset_n;
    logic        intEn;
    logic [15:0] switchLines;
    logic        spiClk;
    logic        csN;
    logic        serialIn;
    logic        serialOut;
    logic        serialOutOe;
    logic        irqN;
    logic        irqOe;
    logic [15:0] maskOut;
    logic [15:0] statusOut;
    logic [31:0] rx;
    int          failures = 0;
    int          checked = 0;

    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    spi_switch_input_monitor u_spi_switch_input_monitor (
        .sys_clk, .reset_n, .spiClk, .csN, .serialIn, .serialOut,
        .serialOutOe, .irqN, .irqOe, .intEn, .switchLines, .maskOut,
        .statusOut);

    link_master u_link_master (
        .spiClk, .csN, .serialIn, .serialOut, .serialOutOe);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Settle time covers sync chain and interrupt logic
    task automatic setIn(input logic [15:0] v, input logic en);
        @(posedge sys_clk);
        switchLines <= v;
        intEn <= en;
        repeat (10) @(posedge sys_clk);
    endtask

    task automatic rd(input int n, input logic [31:0] tx);
        u_link_master.xfer(n, tx, rx);
        repeat (10) @(posedge sys_clk);
    endtask

    task automatic t_reset;
        chk(maskOut, 16'h0000);
        chk(statusOut, 16'h0000);
        chk({14'h0, irqOe, serialOutOe}, 16'h0000);
        chk({15'h0, irqN}, 16'h0000);
    endtask

    task automatic t_read;
        setIn(16'ha5c3, 1'h1);
        chk({15'h0, irqOe}, 16'h0000);
        rd(16, 32'hffff);
        chk(rx[15:0], 16'ha5c3);
        chk(statusOut, 16'ha5c3);
        chk(maskOut, 16'hffff);
        chk({15'h0, serialOutOe}, 16'h0000);
    endtask

    task automatic t_irq;
        setIn(16'ha5c2, 1'h1);
        chk({15'h0, irqOe}, 16'h0001);
        rd(16, 32'h0002);
        chk({15'h0, irqOe}, 16'h0000);
        chk(rx[15:0], 16'ha5c2);
        setIn(16'ha5c3, 1'h1);
        chk({15'h0, irqOe}, 16'h0000);
        setIn(16'ha5c1, 1'h1);
        chk({15'h0, irqOe}, 16'h0001);
    endtask

    task automatic t_enable;
        setIn(16'ha5c1, 1'h0);
        chk({15'h0, irqOe}, 16'h0000);
        setIn(16'h0f0f, 1'h0);
        rd(16, 32'h0002);
        chk(statusOut, 16'ha5c1);
        setIn(16'h0f0f, 1'h1);
        chk({15'h0, irqOe}, 16'h0001);
    endtask

    task automatic t_daisy;
        rd(32, 32'h1234_8001);
        chk(rx[31:16], 16'h0f0f);
        chk(rx[15:0], 16'h1234);
        chk(maskOut, 16'h8001);
    endtask

    task automatic t_soft;
        setIn(16'hf00f, 1'h1);
        chk({15'h0, irqOe}, 16'h0001);
        rd(16, 32'h0000);
        chk(maskOut, 16'h0000);
        chk(statusOut, 16'h0000);
        chk({15'h0, irqOe}, 16'h0000);
    endtask

    initial begin
        reset_n = 1'h0;
        intEn = 1'h0;
        switchLines = 16'h0000;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (5) @(posedge sys_clk);
        t_reset;
        t_read;
        t_irq;
        t_enable;
        t_daisy;
        t_soft;
        test_done;
    end

    // Whole run needs about 22 us
    initial begin
        #100us;
        failures++;
        test_done;
    end
endmodule // spi_switch_input_monitor_tb_top
